// file: core/iosw_pkg.sv
/*
 * iosw_pkg: bit positions, widths and selector codes of the terminal status words.
 * Assumes a single core clock domain; used by core/iosw_status_word.sv.
 */
package iosw_pkg;
	localparam int WORD_WIDTH      = 16;
	localparam int DIGIT_WIDTH     = 4;
	localparam int DIGIT_COUNT     = 4;
	localparam int GEN_INPUT_COUNT = 5;
	localparam int TR_OUTPUT_COUNT = 3;
	// input word layout
	localparam int IN_FWD_BIT      = 0;
	localparam int IN_REV_BIT      = 1;
	localparam int IN_GEN_LSB      = 2;
	localparam int IN_COMM_FWD_BIT = 13;
	localparam int IN_COMM_REV_BIT = 14;
	localparam int IN_COMM_RST_BIT = 15;
	// output word layout
	localparam int OUT_TR_LSB      = 0;
	localparam int OUT_RELAY_BIT   = 4;
	localparam int OUT_ALARM_BIT   = 8;
	localparam logic [WORD_WIDTH-1:0] WORD_RESET = 16'h0000;
	// display mode for link-received commands
	typedef enum logic {
		IOSW_SHOW_SEGMENT,
		IOSW_SHOW_HEX
	} iosw_show_type;
	// source/sink switch: sink means a terminal is active when pulled low
	localparam logic SWITCH_SINK = 1'h0;
endpackage

// file: core/iosw_status_word.sv
/*
 * iosw_status_word: packs control terminal and link command states into 16-bit
 * status words, with a four-digit hex form for the monitor display.
 * Assumes terminal pins are asynchronous to core_clk; link command bits and
 * the command code setting come from logic on core_clk.
 */
`timescale 1ns/100ps
module iosw_status_word (
	// clock and reset
	input  wire logic                             core_clk,
	input  wire logic                             reset,
	// control terminal pins, raw electrical level
	input  wire logic                             forward_run_input,
	input  wire logic                             reverse_run_input,
	input  wire logic [iosw_pkg::GEN_INPUT_COUNT-1:0] general_input,
	input  wire logic                             source_sink_switch,
	// output terminal states, one while conducting or closed
	input  wire logic [iosw_pkg::TR_OUTPUT_COUNT-1:0] transistor_output,
	input  wire logic                             general_relay_output,
	input  wire logic                             alarm_relay_output,
	// commands received over the serial link, one meaning active; code setting one selects hex display
	input  wire logic                             link_forward_run,
	input  wire logic                             link_reverse_run,
	input  wire logic [iosw_pkg::GEN_INPUT_COUNT-1:0] link_general_input,
	input  wire logic                             comm_forward_command,
	input  wire logic                             comm_reverse_command,
	input  wire logic                             comm_fault_reset_command,
	input  wire logic                             comm_command_code_setting,
	// status words
	output logic [iosw_pkg::WORD_WIDTH-1:0]       input_status_word,
	output logic [iosw_pkg::WORD_WIDTH-1:0]       output_status_word,
	output logic [iosw_pkg::WORD_WIDTH-1:0]       link_status_word,
	// display forms: link segment bits and mode, hex digits of all three words
	output logic [iosw_pkg::WORD_WIDTH-1:0]       link_segment_bits,
	output logic                                  link_show_hex,
	output logic [iosw_pkg::WORD_WIDTH-1:0]       input_hex_digits,
	output logic [iosw_pkg::WORD_WIDTH-1:0]       output_hex_digits,
	output logic [iosw_pkg::WORD_WIDTH-1:0]       link_hex_digits
);
	// bit positions of each pin in the synchroniser vector
	localparam int PIN_FWD     = 0;
	localparam int PIN_REV     = 1;
	localparam int PIN_GEN_LSB = 2;
	localparam int PIN_SW      = PIN_GEN_LSB + iosw_pkg::GEN_INPUT_COUNT;
	localparam int PIN_TR_LSB  = PIN_SW + 1;
	localparam int PIN_RELAY   = PIN_TR_LSB + iosw_pkg::TR_OUTPUT_COUNT;
	localparam int PIN_ALARM   = PIN_RELAY + 1;
	localparam int PIN_COUNT   = PIN_ALARM + 1;

	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] sync1_q;
	logic [PIN_COUNT-1:0] sync2_q;
	logic [PIN_COUNT-1:0] sync3_q;
	logic [PIN_COUNT-1:0] stable_q;
	logic [iosw_pkg::WORD_WIDTH-1:0] in_word_d;
	logic [iosw_pkg::WORD_WIDTH-1:0] out_word_d;
	logic [iosw_pkg::WORD_WIDTH-1:0] link_word_d;
	logic                            fwd_s;
	logic                            rev_s;
	logic [iosw_pkg::GEN_INPUT_COUNT-1:0] gen_s;
	logic                            sw_s;
	logic [iosw_pkg::TR_OUTPUT_COUNT-1:0] tr_s;
	logic                            relay_s;
	logic                            alarm_s;
	logic                            active_high;

	assign pin_raw = {alarm_relay_output, general_relay_output, transistor_output,
		source_sink_switch, general_input, reverse_run_input, forward_run_input};

	// three-stage synchronisers; a level counts once stages two and three agree
	// no pulse filter beyond that: a glitch lasting through both stages
	// still reaches the word
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
			always_ff @(posedge core_clk) begin
				if (reset) begin
					stable_q[gi] <= 1'h0;
				end else if (sync2_q[gi] == sync3_q[gi]) begin
					stable_q[gi] <= sync3_q[gi];
				end
			end
		end
	endgenerate

	assign fwd_s   = stable_q[PIN_FWD];
	assign rev_s   = stable_q[PIN_REV];
	assign gen_s   = stable_q[PIN_GEN_LSB +: iosw_pkg::GEN_INPUT_COUNT];
	assign sw_s    = stable_q[PIN_SW];
	assign tr_s    = stable_q[PIN_TR_LSB +: iosw_pkg::TR_OUTPUT_COUNT];
	assign relay_s = stable_q[PIN_RELAY];
	assign alarm_s = stable_q[PIN_ALARM];

	// switch sets level
	// switch is synchronised with the pins so a move never mixes levels
	assign active_high = (sw_s != iosw_pkg::SWITCH_SINK);

	always_comb begin
		in_word_d = iosw_pkg::WORD_RESET;
		in_word_d[iosw_pkg::IN_FWD_BIT] = ~(fwd_s ^ active_high);
		in_word_d[iosw_pkg::IN_REV_BIT] = ~(rev_s ^ active_high);
		in_word_d[iosw_pkg::IN_GEN_LSB +: iosw_pkg::GEN_INPUT_COUNT] =
			~(gen_s ^ {iosw_pkg::GEN_INPUT_COUNT{active_high}});
	end

	always_comb begin
		out_word_d = iosw_pkg::WORD_RESET;
		out_word_d[iosw_pkg::OUT_TR_LSB +: iosw_pkg::TR_OUTPUT_COUNT] = tr_s;
		out_word_d[iosw_pkg::OUT_RELAY_BIT] = relay_s;
		out_word_d[iosw_pkg::OUT_ALARM_BIT] = alarm_s;
	end

	always_comb begin
		link_word_d = iosw_pkg::WORD_RESET;
		link_word_d[iosw_pkg::IN_FWD_BIT] = link_forward_run;
		link_word_d[iosw_pkg::IN_REV_BIT] = link_reverse_run;
		link_word_d[iosw_pkg::IN_GEN_LSB +: iosw_pkg::GEN_INPUT_COUNT] = link_general_input;
		link_word_d[iosw_pkg::IN_COMM_FWD_BIT] = comm_forward_command;
		link_word_d[iosw_pkg::IN_COMM_REV_BIT] = comm_reverse_command;
		link_word_d[iosw_pkg::IN_COMM_RST_BIT] = comm_fault_reset_command;
	end

	// all three words update on one edge so a reader never sees a torn pair
	always_ff @(posedge core_clk) begin
		if (reset) begin
			input_status_word  <= iosw_pkg::WORD_RESET;
			output_status_word <= iosw_pkg::WORD_RESET;
			link_status_word   <= iosw_pkg::WORD_RESET;
		end else begin
			input_status_word  <= in_word_d;
			output_status_word <= out_word_d;
			link_status_word   <= link_word_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_show_hex <= 1'h0;
		end else begin
			link_show_hex <= (comm_command_code_setting == iosw_pkg::IOSW_SHOW_HEX);
		end
	end

	// segment bits cleared in hex mode so only one form is live
	always_ff @(posedge core_clk) begin
		if (reset) begin
			link_segment_bits <= iosw_pkg::WORD_RESET;
		end else begin
			link_segment_bits <= (comm_command_code_setting == iosw_pkg::IOSW_SHOW_HEX)
				? iosw_pkg::WORD_RESET : link_word_d;
		end
	end

	// digits, msd first
	// digit 0 of each output is the most significant nibble so the display
	// can scan left to right without reordering
	genvar di;
	generate
		for (di = 0; di < iosw_pkg::DIGIT_COUNT; di = di + 1) begin : g_digit
			localparam int SRC = (iosw_pkg::DIGIT_COUNT - 1 - di) * iosw_pkg::DIGIT_WIDTH;
			localparam int DST = di * iosw_pkg::DIGIT_WIDTH;
			always_ff @(posedge core_clk) begin
				if (reset) begin
					input_hex_digits[DST +: iosw_pkg::DIGIT_WIDTH] <= '0;
				end else begin
					input_hex_digits[DST +: iosw_pkg::DIGIT_WIDTH] <=
						in_word_d[SRC +: iosw_pkg::DIGIT_WIDTH];
				end
			end

			always_ff @(posedge core_clk) begin
				if (reset) begin
					output_hex_digits[DST +: iosw_pkg::DIGIT_WIDTH] <= '0;
				end else begin
					output_hex_digits[DST +: iosw_pkg::DIGIT_WIDTH] <=
						out_word_d[SRC +: iosw_pkg::DIGIT_WIDTH];
				end
			end

			// link digits blank in segment mode so stale hex never shows
			always_ff @(posedge core_clk) begin
				if (reset) begin
					link_hex_digits[DST +: iosw_pkg::DIGIT_WIDTH] <= '0;
				end else begin
					link_hex_digits[DST +: iosw_pkg::DIGIT_WIDTH] <=
						(comm_command_code_setting == iosw_pkg::IOSW_SHOW_HEX)
						? link_word_d[SRC +: iosw_pkg::DIGIT_WIDTH] : 4'h0;
				end
			end
		end
	endgenerate
endmodule

// file: test/iosw_checker.sv
/*
 * iosw_checker: port-level assertions on the terminal status word block.
 * Assumes one clock domain and that hex digits share the timing of their word.
 */
`timescale 1ns/100ps
module iosw_checker (
	// clock and reset
	input wire logic                                   core_clk, reset,
	// pins and output states
	input wire logic                                   forward_run_input, reverse_run_input,
	input wire logic [iosw_pkg::GEN_INPUT_COUNT-1:0]   general_input, link_general_input,
	input wire logic [iosw_pkg::TR_OUTPUT_COUNT-1:0]   transistor_output,
	input wire logic                                   source_sink_switch, general_relay_output,
	input wire logic                                   alarm_relay_output,
	// link commands
	input wire logic                                   link_forward_run, link_reverse_run,
	input wire logic                                   comm_forward_command, comm_reverse_command,
	input wire logic                                   comm_fault_reset_command,
	input wire logic                                   comm_command_code_setting, link_show_hex,
	// words
	input wire logic [iosw_pkg::WORD_WIDTH-1:0]        input_status_word, output_status_word,
	input wire logic [iosw_pkg::WORD_WIDTH-1:0]        link_status_word, link_segment_bits,
	input wire logic [iosw_pkg::WORD_WIDTH-1:0]        input_hex_digits, output_hex_digits,
	input wire logic [iosw_pkg::WORD_WIDTH-1:0]        link_hex_digits
);
	logic [15:0] in_exp, out_exp, lnk_exp;
	// sink wiring makes a low pin the active one
	assign in_exp = {9'h000, {7{~source_sink_switch}} ^
		{general_input, reverse_run_input, forward_run_input}};
	assign out_exp = {7'h00, alarm_relay_output, 3'h0, general_relay_output, 1'h0,
		transistor_output};
	assign lnk_exp = {comm_fault_reset_command, comm_reverse_command, comm_forward_command,
		6'h00, link_general_input, link_reverse_run, link_forward_run};
	function automatic logic [15:0] swp(input logic [15:0] w);
		return {w[3:0], w[7:4], w[11:8], w[15:12]};
	endfunction
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// pins need six quiet cycles to pass the synchroniser
	sequence s_in_quiet;
		(!reset && $stable(in_exp))[*6];
	endsequence
	sequence s_out_quiet;
		(!reset && $stable(out_exp))[*6];
	endsequence
	property p_in_map; s_in_quiet |=> input_status_word == $past(in_exp); endproperty
	property p_out_map; s_out_quiet |=> output_status_word == $past(out_exp); endproperty
	property p_in_zero; input_status_word[15:7] == 9'h000; endproperty
	property p_out_zero; (output_status_word & 16'hFEE8) == 16'h0000; endproperty
	property p_link; !$past(reset) |-> link_status_word == $past(lnk_exp); endproperty
	property p_show; !$past(reset) |-> link_show_hex == $past(comm_command_code_setting);
	endproperty
	property p_seg; link_segment_bits == (link_show_hex ? 16'h0000 : link_status_word);
	endproperty
	property p_hex;
		input_hex_digits == swp(input_status_word) && output_hex_digits ==
			swp(output_status_word) && link_hex_digits ==
			(link_show_hex ? swp(link_status_word) : 16'h0000);
	endproperty
	a_in_map: assert property (p_in_map) else $error("input word mismatch");
	a_out_map: assert property (p_out_map) else $error("output word mismatch");
	a_in_zero: assert property (p_in_zero) else $error("input unmapped bit set");
	a_out_zero: assert property (p_out_zero) else $error("output unmapped bit set");
	a_link: assert property (p_link) else $error("link word mismatch");
	a_show: assert property (p_show) else $error("show mode mismatch");
	a_seg: assert property (p_seg) else $error("segment bits mismatch");
	a_hex: assert property (p_hex) else $error("hex digit order wrong");
endmodule
bind iosw_status_word iosw_checker chk_u (.*);

// file: test/iosw_terminal_model.sv
/*
 * iosw_terminal_model: control terminal wiring, turns active states into pin levels.
 * Assumes the bench sets the switch position and the active states.
 */
`timescale 1ns/100ps
module iosw_terminal_model (
	input wire logic       source_sink_switch, act_fwd, act_rev,
	input wire logic [4:0] act_gen,
	output logic           forward_run_input, reverse_run_input,
	output logic [4:0]     general_input
);
	assign {general_input, reverse_run_input, forward_run_input} =
		{7{~source_sink_switch}} ^ {act_gen, act_rev, act_fwd};
endmodule

// file: test/test_iosw_status_word.sv
/*
 * test_iosw_status_word: random terminal and link stimulus against a bench model.
 * Assumes the checker is bound by its own file and the wiring model drives the pins.
 */
`timescale 1ns/100ps
module test_iosw_status_word;
	logic        core_clk = 0, reset = 1, act_fwd = 0, act_rev = 0, source_sink_switch = 0;
	logic        general_relay_output = 0, alarm_relay_output = 0, link_forward_run = 0;
	logic        link_reverse_run = 0, comm_forward_command = 0, comm_reverse_command = 0;
	logic        comm_fault_reset_command = 0, comm_command_code_setting = 0, link_show_hex;
	logic        forward_run_input, reverse_run_input;
	logic [4:0]  general_input, act_gen = 0, link_general_input = 0;
	logic [2:0]  transistor_output = 0;
	logic [15:0] input_status_word, output_status_word, link_status_word, link_segment_bits;
	logic [15:0] input_hex_digits, output_hex_digits, link_hex_digits, lexp, iexp, oexp;
	integer      seed = 32'h5be335d7, error_cnt = 0, compares = 0, i;
	iosw_terminal_model wiring_u (.*);
	iosw_status_word dut_u (.*);
	always #20 core_clk = ~core_clk;
	function automatic logic [15:0] swp(input logic [15:0] w);
		return {w[3:0], w[7:4], w[11:8], w[15:12]};
	endfunction
	task check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// run needs about 250 cycles
	initial begin
		#40000;
		error_cnt++;
		summarize;
	end
	initial begin
		repeat (5) @(posedge core_clk);
		#1 reset = 0;
		for (i = 0; i < 240; i++) begin
			// pins held eight cycles to clear the synchroniser
			if (i % 8 == 0) {act_fwd, act_rev, act_gen, source_sink_switch, transistor_output,
				general_relay_output, alarm_relay_output} = $random(seed);
			{link_forward_run, link_reverse_run, link_general_input, comm_forward_command,
				comm_reverse_command, comm_fault_reset_command,
				comm_command_code_setting} = $random(seed);
			lexp = {comm_fault_reset_command, comm_reverse_command, comm_forward_command,
				6'h00, link_general_input, link_reverse_run, link_forward_run};
			iexp = {9'h000, act_gen, act_rev, act_fwd};
			oexp = {7'h00, alarm_relay_output, 3'h0, general_relay_output, 1'h0,
				transistor_output};
			@(posedge core_clk);
			#1;
			check(link_status_word, lexp);
			check(link_segment_bits, comm_command_code_setting ? 16'h0000 : lexp);
			check({15'h0000, link_show_hex}, {15'h0000, comm_command_code_setting});
			check(link_hex_digits, comm_command_code_setting ? swp(lexp) : 16'h0000);
			if (i % 8 == 7) begin
				check(input_status_word, iexp);
				check(output_status_word, oexp);
				check(input_hex_digits, swp(iexp));
				check(output_hex_digits, swp(oexp));
			end
		end
		summarize;
	end
endmodule
